// ### design/sftl_pkg.sv
// Shared constants of the servo fault and travel limit block.
// Assumes a single 200 MHz control clock; no bus clock crossing.
package sftl_pkg;
    localparam int unsigned SFTL_CLK_MHZ = 200;
    localparam logic [7:0] SFTL_MAIN_NONE = 8'h00;
    localparam logic [7:0] SFTL_MAIN_LIMIT = 8'h22;    // 34
    localparam logic [7:0] SFTL_MAIN_SCALE = 8'h33;    // 51
    localparam logic [7:0] SFTL_MAIN_PHASE = 8'h37;    // 55
    localparam logic [7:0] SFTL_MAIN_ESTOP = 8'h57;    // 87
    localparam logic [7:0] SFTL_MAIN_MOTOR = 8'h5f;    // 95
    localparam logic [7:0] SFTL_MAIN_OTHER = 8'h63;    // 99
    localparam logic [7:0] SFTL_MAIN_DIAG = 8'hff;     // Outside the table
    localparam logic [2:0] SFTL_MOTOR_SUB_MAX = 3'h4;
    localparam logic [1:0] SFTL_OT_SEQ_CLEAR = 2'h2;
    localparam int unsigned SFTL_POS_W = 32;
    // Register offsets, byte addresses
    localparam logic [3:0] SFTL_REG_CTRL = 4'h0;
    localparam logic [3:0] SFTL_REG_RANGE = 4'h4;
    localparam logic [3:0] SFTL_REG_ALARM = 4'h8;
    localparam logic [3:0] SFTL_REG_CMD_LO = 4'hc;
    localparam logic [31:0] SFTL_RANGE_RST = 32'h0000_2710;
    localparam logic [31:0] SFTL_CTRL_RST = 32'h0000_0000;
    // Control field positions
    localparam int unsigned SFTL_CTRL_MODE_LSB = 0;   // 2 bits
    localparam int unsigned SFTL_CTRL_OTSEQ_LSB = 2;  // 2 bits
    localparam int unsigned SFTL_CTRL_CLR_BIT = 4;     // Write 1: fault clear
    typedef enum logic [1:0] {
        SFTL_MODE_POS, SFTL_MODE_VEL, SFTL_MODE_TRQ, SFTL_MODE_FULL
    } sftl_mode_e;
endpackage

// ### design/sftl_top.sv
// Fault coding, latching and software travel limit for a servo drive.
// Assumes inputs synchronous to sys_clk_i and an Avalon-MM master.
//
// How it works
// RULE1: scale bits 3..5 give code 51.bit
// RULE2: scale phase A/B/Z breaks give 55.0-2
// RULE3: forced stop input gives code 87.0
// RULE4: motor mismatch gives 95 with sub 0-4
// RULE5: noise detection gives code 99.0
// RULE6: clear with safety abnormal gives 99
// RULE7: self-diagnosis fault gives out-of-table code
// RULE8: starred alarms ignore clear, need power cycle
// RULE9: operator clears scale error then power-cycles
// RULE10: leaving movable range gives code 34
// RULE11: limit check only position/full-closed, servo on
// RULE12: limit alarm requests decelerate and stop
// RULE13: limit check off during trial or fr-meas
// RULE14: no command: range is working range around motor
// RULE15: commands extend range, widened by working range
// RULE16: range zeroed at reset, trial start/end
// RULE17: range held zero while deviation clearing
// RULE18: scale bits 0..2 give code 51.bit
// RULE19: first alarm latched and held stable
// RULE20: clear only clearable, only once cause gone
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module sftl_top
    import sftl_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [5:0] scale_alarm_bits_i,
    input wire logic [2:0] scale_phase_break_i,
    input wire logic forced_stop_i,
    input wire logic motor_mismatch_i,
    input wire logic [2:0] motor_mismatch_sub_i,
    input wire logic noise_fault_i,
    input wire logic self_diag_fault_i,
    input wire logic [1:0] safety_abnormal_i,
    input wire logic fault_clear_input_i,
    input wire logic servo_on_i,
    input wire logic tool_test_active_i,
    input wire logic trial_run_i,
    input wire logic deviation_clear_i,
    input wire logic overtravel_inhibit_i,
    input wire logic cmd_valid_i,
    input wire logic signed [31:0] cmd_delta_i,
    input wire logic signed [31:0] motor_pos_i,
    output logic alarm_o,
    output logic [7:0] alarm_main_o,
    output logic [3:0] alarm_sub_o,
    output logic stop_req_o
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] working_range_setting;
    logic clr_pulse;
    logic waited;
    wire acc = avs_read_i | avs_write_i;
    wire wr_take = avs_write_i & waited;
    wire rd_take = avs_read_i & waited;
    wire [1:0] mode = ctrl[SFTL_CTRL_MODE_LSB +: 2];
    wire [1:0] overtravel_sequence_setting = ctrl[SFTL_CTRL_OTSEQ_LSB +: 2];

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // One wait state: request seen, answer on the next edge
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            waited <= 1'b0;
        end else begin
            waited <= acc & ~waited;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~(acc & ~waited);
        end
    end

    // Control and range writes; clear bit is self-clearing
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl <= SFTL_CTRL_RST;
            working_range_setting <= SFTL_RANGE_RST;
            clr_pulse <= 1'b0;
        end else begin
            clr_pulse <= 1'b0;
            if (wr_take && avs_address_i == SFTL_REG_CTRL) begin
                ctrl <= merge_be(ctrl, avs_writedata_i, avs_byteenable_i)
                        & ~(32'h1 << SFTL_CTRL_CLR_BIT);
                clr_pulse <= avs_writedata_i[SFTL_CTRL_CLR_BIT] & avs_byteenable_i[0];
            end
            if (wr_take && avs_address_i == SFTL_REG_RANGE) begin
                working_range_setting <= merge_be(working_range_setting, avs_writedata_i,
                                                  avs_byteenable_i);
            end
        end
    end

    // ------------------------------------------------------------
    // Travel limit
    // ------------------------------------------------------------
    logic signed [31:0] cmd_lo;
    logic signed [31:0] cmd_hi;
    logic signed [31:0] cmd_pos;    // Accumulated command position
    logic have_cmd;
    logic trial_d;
    // RULE17: deviation clearing
    wire dev_clear = deviation_clear_i |
                     (overtravel_sequence_setting == SFTL_OT_SEQ_CLEAR && overtravel_inhibit_i);
    // RULE16: trial edges
    wire trial_edge = trial_run_i ^ trial_d;
    // Commands are relative moves from the last commanded position
    wire signed [31:0] cmd_end = cmd_pos + cmd_delta_i;
    wire signed [31:0] wr = $signed(working_range_setting);
    // RULE11: mode and servo gating
    // RULE13: tool test masks
    wire lim_en = servo_on_i & ~tool_test_active_i & ~trial_run_i &
                  (mode == SFTL_MODE_POS || mode == SFTL_MODE_FULL);
    // RULE15: widen command range
    wire signed [31:0] lo_bound = cmd_lo - wr;
    wire signed [31:0] hi_bound = cmd_hi + wr;
    wire lim_trip = lim_en & have_cmd & (motor_pos_i < lo_bound || motor_pos_i > hi_bound);

    // Command range tracker; with no command yet, the range anchors on the motor position
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            trial_d <= 1'b0;
        end else begin
            trial_d <= trial_run_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        // RULE16: reset and trial zero
        if (!rst_n_i || trial_edge || dev_clear) begin
            have_cmd <= 1'b0;
            cmd_pos <= 32'sh0;
            cmd_lo <= 32'sh0;
            cmd_hi <= 32'sh0;
        end else if (!have_cmd) begin
            // RULE14: range around motor
            have_cmd <= 1'b1;
            cmd_pos <= motor_pos_i;
            cmd_lo <= motor_pos_i;
            cmd_hi <= motor_pos_i;
        end else if (cmd_valid_i) begin
            // RULE15: extend either end
            cmd_pos <= cmd_end;
            if (cmd_end > cmd_hi) begin
                cmd_hi <= cmd_end;
            end
            if (cmd_end < cmd_lo) begin
                cmd_lo <= cmd_end;
            end
        end
    end

    // ------------------------------------------------------------
    // Alarm coding and latch
    // ------------------------------------------------------------
    logic [7:0] next_main;
    logic [3:0] next_sub;
    logic next_hit;
    logic latched_nc;     // Latched alarm is non-clearable
    wire safety_bad = |safety_abnormal_i;
    wire clr_req = clr_pulse | fault_clear_input_i;

    // Priority coder, diagnosis highest
    always_comb begin
        next_main = SFTL_MAIN_NONE;
        next_sub = 4'h0;
        next_hit = 1'b1;
        if (self_diag_fault_i) begin
            // RULE7: out-of-table code
            next_main = SFTL_MAIN_DIAG;
        end else if (noise_fault_i || (clr_req && safety_bad)) begin
            // RULE5: noise code
            // RULE6: refused clear
            next_main = SFTL_MAIN_OTHER;
        end else if (|scale_alarm_bits_i) begin
            // RULE1: upper scale bits
            // RULE18: lower scale bits
            next_main = SFTL_MAIN_SCALE;
            for (int i = 5; i >= 0; i--) begin
                if (scale_alarm_bits_i[i]) begin
                    next_sub = 4'(i);
                end
            end
        end else if (|scale_phase_break_i) begin
            // RULE2: phase wiring codes
            next_main = SFTL_MAIN_PHASE;
            next_sub = scale_phase_break_i[0] ? 4'h0 : (scale_phase_break_i[1] ? 4'h1 : 4'h2);
        end else if (motor_mismatch_i) begin
            // RULE4: motor mismatch sub
            next_main = SFTL_MAIN_MOTOR;
            next_sub = motor_mismatch_sub_i > SFTL_MOTOR_SUB_MAX ? {1'b0, SFTL_MOTOR_SUB_MAX}
                                                                : {1'b0, motor_mismatch_sub_i};
        end else if (forced_stop_i) begin
            // RULE3: forced stop code
            next_main = SFTL_MAIN_ESTOP;
        end else if (lim_trip) begin
            // RULE10: travel limit alarm
            next_main = SFTL_MAIN_LIMIT;
        end else begin
            next_hit = 1'b0;
        end
    end

    // Estop and travel limit are the only clearable causes
    wire next_nc = next_main != SFTL_MAIN_ESTOP && next_main != SFTL_MAIN_LIMIT;
    // RULE20: cause must be gone
    wire cause_now = alarm_main_o == SFTL_MAIN_ESTOP ? forced_stop_i : lim_trip;
    // RULE8: non-clearable ignores clear
    wire clr_ok = clr_req & ~safety_bad & ~latched_nc & ~cause_now;

    // RULE19: first alarm held
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            alarm_o <= 1'b0;
            alarm_main_o <= SFTL_MAIN_NONE;
            alarm_sub_o <= 4'h0;
            latched_nc <= 1'b0;
        end else if (!alarm_o && next_hit) begin
            alarm_o <= 1'b1;
            alarm_main_o <= next_main;
            alarm_sub_o <= next_sub;
            latched_nc <= next_nc;
        end else if (alarm_o && clr_ok) begin
            alarm_o <= 1'b0;
            alarm_main_o <= SFTL_MAIN_NONE;
            alarm_sub_o <= 4'h0;
        end
    end

    // RULE12: decelerate and stop
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            stop_req_o <= 1'b0;
        end else begin
            stop_req_o <= (alarm_o & ~clr_ok) | (~alarm_o & next_hit);
        end
    end

    // Read mux
    wire [31:0] rd_mux = avs_address_i == SFTL_REG_CTRL ? ctrl :
                         avs_address_i == SFTL_REG_RANGE ? working_range_setting :
                         avs_address_i == SFTL_REG_ALARM ?
                             {19'h0, alarm_o, alarm_sub_o, alarm_main_o} :
                         avs_address_i == SFTL_REG_CMD_LO ? cmd_lo : 32'h0;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0;
        end else if (acc & ~waited) begin
            avs_readdata_o <= avs_read_i ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Fresh fault seen while nothing is latched
    sequence s_fresh_fault;
        !alarm_o && next_hit;
    endsequence

    // Clear accepted on a latched alarm
    sequence s_clear_taken;
        alarm_o && clr_ok;
    endsequence

    a_limit_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE10
        !alarm_o && !self_diag_fault_i && !noise_fault_i && !clr_req && scale_alarm_bits_i == 6'h0
        && scale_phase_break_i == 3'h0 && !motor_mismatch_i && !forced_stop_i && lim_trip
        |=> alarm_main_o == SFTL_MAIN_LIMIT)
        else $error("travel limit code missing");
    a_estop_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE3
        s_fresh_fault ##0 next_main == SFTL_MAIN_ESTOP
        |=> alarm_main_o == 8'h57 && alarm_sub_o == 4'h0)
        else $error("forced stop code wrong");
    a_scale_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE1
        !alarm_o && !self_diag_fault_i && !noise_fault_i && !(clr_req && safety_bad)
        && scale_alarm_bits_i == 6'h08 |=> alarm_main_o == 8'h33 && alarm_sub_o == 4'h3)
        else $error("scale code wrong");
    a_scale_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE18
        !alarm_o && !self_diag_fault_i && !noise_fault_i && !(clr_req && safety_bad)
        && scale_alarm_bits_i == 6'h01 |=> alarm_main_o == 8'h33 && alarm_sub_o == 4'h0)
        else $error("low scale code wrong");
    a_phase_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE2
        s_fresh_fault ##0 next_main == SFTL_MAIN_PHASE && scale_phase_break_i == 3'h4
        |=> alarm_main_o == 8'h37 && alarm_sub_o == 4'h2)
        else $error("phase code wrong");
    a_motor_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE4
        s_fresh_fault ##0 next_main == SFTL_MAIN_MOTOR
        |=> alarm_main_o == 8'h5f && alarm_sub_o < 4'h5)
        else $error("motor code wrong");
    a_noise_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE5
        !alarm_o && noise_fault_i && !self_diag_fault_i
        |=> alarm_main_o == 8'h63 && alarm_sub_o == 4'h0)
        else $error("noise code wrong");
    a_refuse_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE6
        !alarm_o && !self_diag_fault_i && clr_req && safety_bad |=> alarm_main_o == 8'h63)
        else $error("unsafe clear not refused");
    a_diag_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
        !alarm_o && self_diag_fault_i |=> alarm_main_o == SFTL_MAIN_DIAG)
        else $error("diagnosis code wrong");
    a_nc_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE8
        alarm_o && latched_nc |=> alarm_o && $stable(alarm_main_o))
        else $error("non-clearable alarm dropped");
    a_hold_stable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE19
        alarm_o && !clr_ok |=> $stable(alarm_sub_o) && alarm_o)
        else $error("latched alarm changed");
    a_clear_done: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE20
        s_clear_taken |=> !alarm_o && !stop_req_o)
        else $error("accepted clear not applied");
    a_stop_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE12
        alarm_o |-> ##1 stop_req_o || !alarm_o)
        else $error("stop not requested");
    a_mode_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE13
        !servo_on_i || tool_test_active_i |-> !lim_trip)
        else $error("limit check not gated");
    a_limit_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE11
        mode == SFTL_MODE_VEL || mode == SFTL_MODE_TRQ |-> !lim_trip)
        else $error("limit check active in wrong mode");
    a_range_cover: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE15
        have_cmd |-> cmd_lo <= cmd_pos && cmd_pos <= cmd_hi)
        else $error("command range misses command");
    a_trial_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE16
        trial_edge |=> !have_cmd && cmd_lo == 32'sh0 && cmd_hi == 32'sh0)
        else $error("range not zeroed at trial edge");
    a_range_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE17
        dev_clear |=> cmd_lo == 32'sh0 && cmd_hi == 32'sh0 && !have_cmd)
        else $error("range not zeroed");
endmodule
`default_nettype wire

// ### test/sftl_scale_model.sv
// Partner model: external position scale that latches its own status faults.
// Assumes the bench names one fault at a time and clears the scale during a power cycle.
`timescale 1ns/1ps
`default_nettype none
module sftl_scale_model (
    input wire logic sys_clk_i,
    input wire logic [3:0] inject_i,
    input wire logic panel_clear_i,
    output logic [5:0] scale_alarm_bits_o,
    output logic [2:0] scale_phase_break_o
);
    initial scale_alarm_bits_o = 6'h00;
    initial scale_phase_break_o = 3'h0;
    // Faults stay up inside the scale, so the drive keeps seeing them
    always @(posedge sys_clk_i) begin
        if (panel_clear_i) begin
            scale_alarm_bits_o <= 6'h00;
            scale_phase_break_o <= 3'h0;
        end else if (inject_i < 4'h6) begin
            scale_alarm_bits_o[inject_i] <= 1'b1;
        end else if (inject_i < 4'h9) begin
            scale_phase_break_o[inject_i - 4'h6] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### test/test_servo_fault_and_travel_limit.sv
// Self-checking bench for the fault coder and software travel limit.
// Assumes a 200 MHz clock, Avalon-MM register access and a scale model.
`timescale 1ns/1ps
`default_nettype none
module test_servo_fault_and_travel_limit import sftl_pkg::*; ();
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, estop = 1'b0, mm = 1'b0;
    logic noise = 1'b0, diag = 1'b0, clr = 1'b0, servo = 1'b0, tool = 1'b0, trial = 1'b0;
    logic devclr = 1'b0, otinh = 1'b0, cmd_v = 1'b0, panel_clr = 1'b0;
    logic alarm, wait_rq, stop;
    logic [3:0] addr = 4'h0, inj = 4'hf, a_sub;
    logic [2:0] mm_sub = 3'h0, phase;
    logic [1:0] safety = 2'h0;
    logic [5:0] sbits;
    logic [7:0] a_main;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic signed [31:0] cmd_d = 32'sh0, mpos = 32'sh0;
    int mismatches = 0, checks_done = 0;

    always #2.5 clk = ~clk;

    sftl_scale_model u_scale (.sys_clk_i(clk), .inject_i(inj), .panel_clear_i(panel_clr),
        .scale_alarm_bits_o(sbits), .scale_phase_break_o(phase));

    sftl_top u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq), .scale_alarm_bits_i(sbits),
        .scale_phase_break_i(phase), .forced_stop_i(estop), .motor_mismatch_i(mm),
        .motor_mismatch_sub_i(mm_sub), .noise_fault_i(noise), .self_diag_fault_i(diag),
        .safety_abnormal_i(safety), .fault_clear_input_i(clr), .servo_on_i(servo),
        .tool_test_active_i(tool), .trial_run_i(trial), .deviation_clear_i(devclr),
        .overtravel_inhibit_i(otinh), .cmd_valid_i(cmd_v), .cmd_delta_i(cmd_d),
        .motor_pos_i(mpos), .alarm_o(alarm), .alarm_main_o(a_main), .alarm_sub_o(a_sub),
        .stop_req_o(stop));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic timeout();
        mismatches++;
        $display("CHECK FAILED wait expected done seen timeout");
        test_done();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Request held until waitrequest is sampled low, data taken at that edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (wait_rq === 1'b0) break;
        end
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 50) timeout();
    endtask

    task automatic wait_alarm(input logic [11:0] code, input logic sub_chk);
        int i;
        for (i = 0; i < 20 && alarm !== 1'b1; i++) @(posedge clk);
        if (i == 20) timeout();
        chk("alarm main", {24'h0, a_main}, {24'h0, code[7:0]});
        if (sub_chk) chk("alarm sub", {28'h0, a_sub}, {28'h0, code[11:8]});
    endtask

    // Power cycle: the scale is cleared at its panel while reset is held
    task automatic pwr();
        @(posedge clk);
        rst_n <= 1'b0;
        panel_clr <= 1'b1;
        cyc(5);
        rst_n <= 1'b1;
        panel_clr <= 1'b0;
    endtask

    task automatic clear_pulse();
        @(posedge clk);
        clr <= 1'b1;
        cyc(2);
        clr <= 1'b0;
        cyc(3);
    endtask

    // Fault source k: 0-5 scale bits, 6-8 phases, 9 stop, 10-14 motor, 15 noise, 16 diag
    task automatic set_src(input int k, input logic v);
        @(posedge clk);
        if (k < 9) inj <= v ? 4'(k) : 4'hf;
        else if (k == 9) estop <= v;
        else if (k < 15) begin
            mm <= v;
            mm_sub <= 3'(k - 10);
        end else if (k == 15) noise <= v;
        else diag <= v;
    endtask

    function automatic logic [11:0] expect_code(input int k);
        case (k) inside
            [0:5]: return {4'(k), SFTL_MAIN_SCALE};
            [6:8]: return {4'(k - 6), SFTL_MAIN_PHASE};
            9: return {4'h0, SFTL_MAIN_ESTOP};
            [10:14]: return {4'(k - 10), SFTL_MAIN_MOTOR};
            15: return {4'h0, SFTL_MAIN_OTHER};
            default: return {4'h0, SFTL_MAIN_DIAG};
        endcase
    endfunction

    task automatic cmd(input logic signed [31:0] d);
        @(posedge clk);
        cmd_v <= 1'b1;
        cmd_d <= d;
        @(posedge clk);
        cmd_v <= 1'b0;
    endtask

    // Motor excursion, then back home and clear; stop must follow the alarm
    task automatic probe(input logic signed [31:0] p, input logic exp);
        @(posedge clk);
        mpos <= p;
        cyc(6);
        chk("limit alarm", {31'h0, alarm}, {31'h0, exp});
        if (exp) chk("limit code", {24'h0, a_main}, {24'h0, SFTL_MAIN_LIMIT});
        if (exp) chk("stop request", {31'h0, stop}, 32'h1);
        mpos <= 32'sh0;
        clear_pulse();
        chk("limit cleared", {31'h0, alarm}, 32'h0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(5);
        rst_n <= 1'b1;
        bus(1'b0, SFTL_REG_RANGE, 32'h0);
        chk("range reset", got, SFTL_RANGE_RST);
        bus(1'b0, SFTL_REG_CTRL, 32'h0);
        chk("ctrl reset", got, SFTL_CTRL_RST);
        bus(1'b1, SFTL_REG_ALARM, 32'hfff);
        bus(1'b0, SFTL_REG_ALARM, 32'h0);
        chk("alarm read only", got, 32'h0);
        bus(1'b0, 4'h1, 32'h0);
        chk("unmapped read", got, 32'h0);
        // Every fault code except travel limit 34, then a clear attempt once the cause is withdrawn
        for (int k = 0; k < 17; k++) begin
            pwr();
            set_src(k, 1'b1);
            wait_alarm(expect_code(k), k != 16);
            bus(1'b0, SFTL_REG_ALARM, 32'h0);
            if (k != 16) chk("alarm reg", got, {19'h0, 1'b1, expect_code(k)});
            set_src(k, 1'b0);
            clear_pulse();
            chk("clear honoured", {31'h0, ~alarm}, {31'h0, k == 9});
        end
        // First alarm held; clear refused while its cause persists
        pwr();
        set_src(9, 1'b1);
        set_src(15, 1'b1);
        clear_pulse();
        chk("first alarm held", {24'h0, a_main}, {24'h0, SFTL_MAIN_ESTOP});
        set_src(15, 1'b0);
        set_src(9, 1'b0);
        bus(1'b1, SFTL_REG_CTRL, 32'h10);
        cyc(3);
        chk("register clear", {31'h0, alarm}, 32'h0);
        @(posedge clk);
        safety <= 2'b10;
        clear_pulse();
        wait_alarm({4'h0, SFTL_MAIN_OTHER}, 1'b1);
        @(posedge clk);
        safety <= 2'b00;
        pwr();
        cyc(5);
        chk("power cycle recovers", {31'h0, alarm}, 32'h0);
        // ----------------------------------------
        // Software travel limit
        // ----------------------------------------
        bus(1'b1, SFTL_REG_RANGE, 32'd100);
        @(posedge clk);
        servo <= 1'b1;
        cyc(3);
        probe(32'sd50, 1'b0);
        probe(32'sd150, 1'b1);
        cmd(32'sd200);
        cmd(-32'sd500);
        bus(1'b0, SFTL_REG_CMD_LO, 32'h0);
        chk("command low end", got, 32'hffff_fed4);
        probe(32'sd250, 1'b0);
        probe(-32'sd350, 1'b0);
        probe(-32'sd450, 1'b1);
        probe(32'sd350, 1'b1);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, SFTL_REG_CTRL, 32'(m));
            probe(32'sd1000, m == 0 || m == 3);
        end
        bus(1'b1, SFTL_REG_CTRL, 32'h0);
        servo <= 1'b0;
        probe(32'sd1000, 1'b0);
        servo <= 1'b1;
        tool <= 1'b1;
        probe(32'sd1000, 1'b0);
        tool <= 1'b0;
        trial <= 1'b1;
        probe(32'sd1000, 1'b0);
        trial <= 1'b0;
        cyc(3);
        probe(32'sd250, 1'b1);
        cmd(32'sd300);
        devclr <= 1'b1;
        cyc(2);
        devclr <= 1'b0;
        probe(32'sd250, 1'b1);
        cmd(32'sd300);
        bus(1'b1, SFTL_REG_CTRL, {28'h0, SFTL_OT_SEQ_CLEAR, 2'b00});
        otinh <= 1'b1;
        cyc(2);
        otinh <= 1'b0;
        probe(32'sd250, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
